// >>> core/ext_irq_vectoring.v
// Purpose: External pin interrupt qualification and interrupt vectoring sequence
// Assumes: Pin and peripheral flags synchronous to clk; CPU gives instr_done
// Notes:   Stack and vector bytes are presented as a one-byte-per-cycle stream
`include "irq_vec_map.vh"
module ext_irq_vectoring (
  input  wire                clk,
  input  wire                rst_n,
  input  wire                pin_in,
  input  wire                stop_mode,
  input  wire                pin_intr_enable,
  input  wire                detect_polarity_select,
  input  wire                edge_level_mode_select,
  input  wire                pin_local_intr_enable,
  input  wire                ack_write,
  input  wire                pullup_select,
  input  wire [`SRC_MSB:0]   src_flag,
  input  wire [`SRC_MSB:0]   src_enable,
  input  wire                software_trap,
  input  wire                global_mask,
  input  wire                instr_done,
  input  wire [7:0]          prog_counter_low,
  input  wire [7:0]          prog_counter_high,
  input  wire [7:0]          index_reg,
  input  wire [7:0]          accum_reg,
  input  wire [7:0]          condition_code_reg,
  output reg                 pin_pending_flag,
  output reg  [7:0]          pin_intr_ctrl_reg,
  output reg                 pin_level_high,
  output reg                 pull_up_en,
  output reg                 pull_down_en,
  output reg                 wake_out,
  output reg                 cpu_irq,
  output reg                 stack_we,
  output reg  [7:0]          stack_data,
  output reg  [7:0]          stack_ptr,
  output reg                 set_mask,
  output reg                 vec_fetch,
  output reg  [15:0]         vec_addr,
  output reg  [4:0]          vec_taken,
  output reg                 seq_busy
);
  reg        rst_meta;
  reg        rst_sync_n;
  reg        pin_prev;
  reg        wake_latch;
  reg        wake_meta;
  reg        wake_seen;
  reg [7:0]  state;
  reg [7:0]  next_state;
  reg [4:0]  win_num;
  reg [4:0]  next_win;
  reg        any_req;
  reg        low_byte;
  wire [15:0] rom_addr;
  integer    i;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta   <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta   <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  wire pin_asserted = detect_polarity_select ? pin_in : ~pin_in;
  wire pin_armed    = pin_intr_enable;
  wire edge_event   = pin_armed & pin_asserted & ~pin_prev;
  wire level_hold   = pin_armed & edge_level_mode_select & pin_asserted;
  wire pin_req      = pin_pending_flag & pin_local_intr_enable;

  // Asynchronous wake latch: needs no clock while stopped
  always @(posedge pin_asserted or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      wake_latch <= 1'b0;
    end else begin
      wake_latch <= 1'b1;
    end
  end

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      pin_prev         <= 1'b1;
      pin_pending_flag <= 1'b0;
      pin_intr_ctrl_reg <= 8'h00;
      pin_level_high   <= 1'b0;
      pull_up_en       <= 1'b0;
      pull_down_en     <= 1'b0;
      wake_meta        <= 1'b0;
      wake_seen        <= 1'b0;
      wake_out         <= 1'b0;
      cpu_irq          <= 1'b0;
    end else begin
      // Prev starts asserted so a pin already active at enable is not an edge
      pin_prev <= pin_armed ? pin_asserted : 1'b1;
      // Set and hold win over the acknowledge
      if (edge_event | level_hold) begin
        pin_pending_flag <= 1'b1;
      end else if (ack_write | ~pin_armed) begin
        pin_pending_flag <= 1'b0;
      end
      pin_intr_ctrl_reg <= {2'b00, detect_polarity_select, pin_intr_enable,
                            pin_pending_flag, 1'b0, pin_local_intr_enable,
                            edge_level_mode_select};
      pin_level_high <= pin_armed & pin_in;
      pull_up_en     <= pin_armed & pullup_select & ~detect_polarity_select;
      pull_down_en   <= pin_armed & pullup_select & detect_polarity_select;
      wake_meta      <= wake_latch;
      wake_seen      <= wake_meta;
      // Latch is unclocked, so only the second stage may feed logic
      wake_out       <= wake_seen & stop_mode & pin_armed;
      // Global mask is applied by the core at entry, not on the request line
      cpu_irq        <= any_req;
    end
  end

  // Fixed priority scan, lowest number first
  always @* begin
    next_win = `VEC_NUM_MAX;
    any_req  = 1'b0;
    for (i = `SRC_MSB; i >= 0; i = i - 1) begin
      if (src_flag[i] & src_enable[i]) begin
        next_win = i[4:0] + `VEC_NUM_FIRST_SRC;
        any_req  = 1'b1;
      end
    end
    if (pin_req) begin
      next_win = `VEC_NUM_PIN;
      any_req  = 1'b1;
    end
    if (software_trap) begin
      next_win = `VEC_NUM_TRAP;
      any_req  = 1'b1;
    end
  end
  // Numbers 26 to 31 never arise from hardware sources

  always @* begin
    next_state = state;
    case (state)
      `STATE_IDLE: if (instr_done & any_req & (software_trap | ~global_mask))
                     next_state = `STATE_PCL;
      `STATE_PCL:  next_state = `STATE_PCH;
      `STATE_PCH:  next_state = `STATE_X;
      `STATE_X:    next_state = `STATE_A;
      `STATE_A:    next_state = `STATE_CCR;
      `STATE_CCR:  next_state = `STATE_VHI;
      `STATE_VHI:  next_state = `STATE_VLO;
      `STATE_VLO:  next_state = `STATE_IDLE;
      default:     next_state = `STATE_IDLE;
    endcase
  end

  always @* begin
    low_byte = (state == `STATE_VHI);
  end

  vector_rom u_rom (
    .clk        (clk),
    .rst_sync_n (rst_sync_n),
    .vec_num    (win_num),
    .low_byte   (low_byte),
    .fetch_addr (rom_addr)
  );

  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state      <= `STATE_IDLE;
      win_num    <= `VEC_NUM_RESET;
      stack_we   <= 1'b0;
      stack_data <= 8'h00;
      stack_ptr  <= `STACK_RESET;
      set_mask   <= 1'b0;
      vec_fetch  <= 1'b0;
      vec_addr   <= `VEC_TOP;
      vec_taken  <= `VEC_NUM_RESET;
      seq_busy   <= 1'b0;
    end else begin
      state    <= next_state;
      stack_we <= 1'b0;
      set_mask <= 1'b0;
      vec_fetch <= 1'b0;
      seq_busy <= (next_state != `STATE_IDLE);
      if (state == `STATE_IDLE && next_state == `STATE_PCL) begin
        // Winner frozen at entry so the fetched vector matches the stacked frame
        win_num <= next_win;
      end
      case (state)
        `STATE_PCL: begin stack_we <= 1'b1; stack_data <= prog_counter_low; end
        `STATE_PCH: begin stack_we <= 1'b1; stack_data <= prog_counter_high; end
        `STATE_X:   begin stack_we <= 1'b1; stack_data <= index_reg; end
        `STATE_A:   begin stack_we <= 1'b1; stack_data <= accum_reg; end
        `STATE_CCR: begin stack_we <= 1'b1; stack_data <= condition_code_reg; end
        `STATE_VHI: begin set_mask <= 1'b1; vec_fetch <= 1'b1; vec_addr <= rom_addr; end
        `STATE_VLO: begin vec_fetch <= 1'b1; vec_addr <= rom_addr; vec_taken <= win_num; end
        default:    begin end
      endcase
      if (stack_we) begin
        stack_ptr <= stack_ptr - 8'h01;
      end
    end
  end
endmodule

// >>> pkg/irq_vec_map.vh
// Purpose: Constants for the external pin interrupt and vectoring block
// Assumes: 8-bit control register image, 16-bit vector addresses
// Notes:   Included by bare name
`ifndef IRQ_VEC_MAP_VH
`define IRQ_VEC_MAP_VH
`define CTRL_FLAG_BIT   3
`define CTRL_ACK_BIT    2
`define CTRL_IE_BIT     1
`define CTRL_MOD_BIT    0
`define CTRL_PE_BIT     4
`define CTRL_EDG_BIT    5
`define VEC_TOP         16'hfffe
`define VEC_NUM_RESET   5'h00
`define VEC_NUM_TRAP    5'h01
`define VEC_NUM_PIN     5'h02
`define VEC_NUM_FIRST_SRC 5'h03
`define VEC_NUM_LAST_HW 5'h19
`define VEC_NUM_USER_LO 5'h1a
`define VEC_NUM_MAX     5'h1f
`define SRC_COUNT       23
`define SRC_MSB         22
`define STATE_IDLE      8'h01
`define STATE_PCL       8'h02
`define STATE_PCH       8'h04
`define STATE_X         8'h08
`define STATE_A         8'h10
`define STATE_CCR       8'h20
`define STATE_VHI       8'h40
`define STATE_VLO       8'h80
`define STACK_RESET     8'hff
`endif

// >>> core/vector_rom.v
// Purpose: Vector address lookup, registered output
// Assumes: Vector n occupies two bytes at top minus two times n
// Notes:   High byte at the lower address
`include "irq_vec_map.vh"
module vector_rom (
  input  wire        clk,
  input  wire        rst_sync_n,
  input  wire [4:0]  vec_num,
  input  wire        low_byte,
  output reg  [15:0] fetch_addr
);
  wire [15:0] base = `VEC_TOP - {10'h000, vec_num, 1'b0};
  always @(posedge clk or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fetch_addr <= `VEC_TOP;
    end else begin
      fetch_addr <= base + {15'h0000, low_byte};
    end
  end
endmodule

// >>> tb/pin_vec_checker_sva.sv
// Purpose: Temporal checks on the pin interrupt and vectoring block
// Assumes: One clock, asynchronous active-low reset
// Notes:   Bound to every instance of the block
module pin_vec_checker (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        pin_in,
  input wire logic        pin_intr_enable,
  input wire logic        detect_polarity_select,
  input wire logic        edge_level_mode_select,
  input wire logic        pin_local_intr_enable,
  input wire logic        pullup_select,
  input wire logic        pin_pending_flag,
  input wire logic        pin_level_high,
  input wire logic        pull_up_en,
  input wire logic        pull_down_en,
  input wire logic        cpu_irq,
  input wire logic        stack_we,
  input wire logic        set_mask,
  input wire logic        vec_fetch,
  input wire logic        seq_busy,
  input wire logic [15:0] vec_addr,
  input wire logic [4:0]  vec_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  // Block releases its own reset two edges late; wait one edge more before checking
  logic [2:0] live;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live <= 3'h0;
    end else begin
      live <= {live[1:0], 1'b1};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!live[2]);
  wire asserted = (pin_in == detect_polarity_select);
  a_flag_needs_enable: assert property (!pin_intr_enable |=> !pin_pending_flag)
    else $error("pending flag set while pin disabled");
  a_local_gate: assert property (pin_pending_flag && pin_local_intr_enable |=> cpu_irq)
    else $error("enabled pending flag gave no request");
  a_level_hold: assert property (edge_level_mode_select && pin_intr_enable && pin_pending_flag
    && asserted |=> pin_pending_flag) else $error("flag dropped while level held");
  a_rise_pulldown: assert property (pin_intr_enable && detect_polarity_select
    && pullup_select |=> pull_down_en && !pull_up_en) else $error("resistor not pulldown");
  a_level_seen: assert property (pin_intr_enable |=> pin_level_high == $past(pin_in))
    else $error("pin level not visible");
  a_stack_order: assert property ($rose(seq_busy) |=> stack_we [*5] ##1 (set_mask
    && vec_fetch) ##1 (vec_fetch && !set_mask)) else $error("entry sequence out of order");
  a_vec_pair: assert property (vec_fetch && set_mask |=> vec_addr == $past(vec_addr) + 16'h1)
    else $error("low vector byte not at next address");
  a_vec_map: assert property (vec_fetch && !set_mask |->
    vec_addr == 16'hffff - {10'h000, vec_taken, 1'b0}) else $error("vector address wrong");
  a_vec_range: assert property (vec_fetch && !set_mask |->
    vec_taken >= 5'h01 && vec_taken <= 5'h19) else $error("vector number outside hardware range");
  c_pin_vector: cover property (vec_fetch && !set_mask && vec_taken == 5'h02);
  c_level_hold: cover property (edge_level_mode_select && pin_pending_flag && asserted);
  c_pulldown: cover property (pull_down_en);
endmodule
bind ext_irq_vectoring pin_vec_checker u_chk (.*);

// >>> tb/cpu_core_model.sv
// Purpose: CPU side partner: instruction boundaries, register values, stack capture
// Assumes: Boundary spacing set by gap, changed only between sequences
// Notes:   Frame keeps the last five stacked bytes, first one on top
module cpu_core_model (
  input  wire logic       clk,
  input  wire logic [3:0] gap,
  input  wire logic       stack_we,
  input  wire logic [7:0] stack_data,
  output logic            instr_done,
  output logic [7:0]      prog_counter_low,
  output logic [7:0]      prog_counter_high,
  output logic [7:0]      index_reg,
  output logic [7:0]      accum_reg,
  output logic [7:0]      condition_code_reg,
  output logic [39:0]     frame
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt = 4'h0;
  assign prog_counter_low = 8'h34;
  assign prog_counter_high = 8'h12;
  assign index_reg = 8'h56;
  assign accum_reg = 8'h78;
  assign condition_code_reg = 8'h9a;
  initial instr_done = 1'b0;
  initial frame = 40'h0;
  // Boundary pulse every gap+1 cycles; slow gaps stretch the take point
  always @(posedge clk) begin
    cnt <= (cnt >= gap) ? 4'h0 : cnt + 4'h1;
    instr_done <= (cnt >= gap);
    if (stack_we)
      frame <= {frame[31:0], stack_data};
  end
endmodule

// >>> tb/tb_top.sv
// Purpose: Directed bench for pin qualification and vectoring
// Assumes: Inputs change 2 ns after the rising edge
// Notes:   Falling polarity first, so the pin idles high
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, rst_n = 0, pin_in = 1, stop_mode = 0, pin_intr_enable = 0, ack_write = 0;
  logic detect_polarity_select = 0, edge_level_mode_select = 0, pin_local_intr_enable = 0;
  logic pullup_select = 0, software_trap = 0, global_mask = 1;
  logic [22:0] src_flag = '0, src_enable = '0;
  logic [3:0] gap = 4'h1;
  wire instr_done, pin_pending_flag, pin_level_high, pull_up_en, pull_down_en, wake_out, cpu_irq;
  wire stack_we, set_mask, vec_fetch, seq_busy;
  wire [7:0] prog_counter_low, prog_counter_high, index_reg, accum_reg, condition_code_reg;
  wire [7:0] stack_data, stack_ptr, pin_intr_ctrl_reg;
  wire [15:0] vec_addr;
  wire [4:0] vec_taken;
  wire [39:0] frame;
  int errors = 0, tests_run = 0;
  logic [7:0] sp_exp = 8'hff;
  ext_irq_vectoring u_dut (.*);
  cpu_core_model u_cpu (.clk(clk), .gap(gap), .stack_we(stack_we), .stack_data(stack_data),
    .instr_done(instr_done), .prog_counter_low(prog_counter_low),
    .prog_counter_high(prog_counter_high), .index_reg(index_reg), .accum_reg(accum_reg),
    .condition_code_reg(condition_code_reg), .frame(frame));
  initial forever #25 clk = ~clk;
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ack;
    ack_write = 1;
    step(1);
    ack_write = 0;
    step(1);
  endtask
  // Waits for the low vector fetch, then checks vector and stacked frame
  task automatic take(input logic [4:0] n);
    int k;
    k = 0;
    while (!(vec_fetch === 1'b1 && set_mask === 1'b0) && k < 60) begin
      step(1);
      k++;
    end
    sp_exp = sp_exp - 8'h05;
    chk({vec_fetch, set_mask}, 2'b10);
    chk(vec_taken, n);
    chk(vec_addr, 16'hffff - {10'h000, n, 1'b0});
    chk(frame, 40'h341256789a);
    chk(stack_ptr, sp_exp);
  endtask
  task automatic summarize;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    #100000;
    errors++;
    summarize;
  end
  initial begin
    step(2);
    rst_n = 1;
    step(4);
    chk(vec_addr, 16'hfffe);
    chk(stack_ptr, 8'hff);
    pin_in = 0;
    step(2);
    chk(pin_pending_flag, 0);
    pin_in = 1;
    pin_intr_enable = 1;
    step(2);
    pin_in = 0;
    step(2);
    chk(pin_pending_flag, 1);
    chk(pin_level_high, 0);
    chk(cpu_irq, 0);
    ack;
    chk(pin_pending_flag, 0);
    pin_in = 1;
    edge_level_mode_select = 1;
    step(1);
    pin_in = 0;
    step(2);
    ack;
    chk(pin_pending_flag, 1);
    pin_in = 1;
    step(1);
    ack;
    chk(pin_pending_flag, 0);
    edge_level_mode_select = 0;
    detect_polarity_select = 1;
    pullup_select = 1;
    pin_in = 0;
    step(2);
    chk({pull_up_en, pull_down_en}, 2'b01);
    pin_in = 1;
    pin_local_intr_enable = 1;
    step(4);
    chk({pin_pending_flag, cpu_irq, seq_busy}, 3'b110);
    chk(pin_intr_ctrl_reg, 8'h3a);
    global_mask = 0;
    take(5'h02);
    global_mask = 1;
    ack;
    step(10);
    software_trap = 1;
    src_flag[0] = 1;
    src_enable[0] = 1;
    pin_in = 0;
    step(1);
    pin_in = 1;
    take(5'h01);
    software_trap = 0;
    step(10);
    global_mask = 0;
    take(5'h02);
    global_mask = 1;
    ack;
    step(10);
    gap = 4'h5;
    global_mask = 0;
    take(5'h03);
    global_mask = 1;
    src_flag = '0;
    pin_in = 0;
    step(10);
    rst_n = 0;
    step(2);
    rst_n = 1;
    step(4);
    stop_mode = 1;
    step(2);
    chk(wake_out, 0);
    pin_in = 1;
    step(4);
    chk(wake_out, 1);
    summarize;
  end
endmodule
